// ===== design/aifc_pkg.sv
package aifc_pkg;

  // Word offsets of the per-axis individual-function words in the interface
  // data block. Not all are multiples of four, so they stay as indices.
  localparam logic [7:0] AXIS1_FUNC_IDX = 8'hbc;
  localparam logic [7:0] AXIS2_FUNC_IDX = 8'hc2;
  localparam logic [7:0] AXIS3_FUNC_IDX = 8'hc8;

  // Bit positions inside an individual-function word.
  localparam int BIT_PROG = 0;
  localparam int BIT_TRIG = 1;
  localparam int BIT_DDIS = 2;
  localparam int BIT_FOLL = 3;

  // Value of a function word after restart: programmer mode set only.
  localparam logic [15:0] FUNC_RESET = 16'h0001;

  // Axis status as seen by this block.
  typedef enum logic [1:0] {
    AIFC_ST_COMPLETED,
    AIFC_ST_INTERRUPTED,
    AIFC_ST_RUNNING
  } aifc_axis_st_t;

  // Per-axis process inputs from the positioning core and encoder side.
  typedef struct packed {
    logic incremental;
    logic has_zero_mark;
    logic zero_mark;
    logic past_reduction;
    logic af_pending;
    logic sim_on_cmd;
    logic sim_off_cmd;
    logic ext_error;
    logic rapid;
    logic below_changeover;
    logic sim_dir_rev;
    logic [31:0] rapid_speed;
    logic [31:0] creep_speed;
    logic [31:0] enc_position;
    logic [31:0] ref_coord;
    logic [31:0] offset;
    logic [15:0] track_enable;
    logic [15:0] cam_states;
    aifc_axis_st_t status;
  } aifc_proc_in_t;

  // Per-axis status outputs.
  typedef struct packed {
    logic prog_mode;
    logic trig_active;
    logic drive_disable;
    logic follow_up;
    logic synchronized;
    logic sim_running;
    logic abort_mode;
    logic adaption_skip;
    logic zero_speed_mon;
    logic adaption_cont;
    logic [31:0] position;
    logic [15:0] cam_out;
    logic [7:0] dig_out;
  } aifc_axis_out_t;

endpackage

// ===== design/aifc_axis_ctrl.sv
`timescale 1ns/1ns

module aifc_axis_ctrl #(
  parameter int NUM_AXES = 3,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Interface data block word access from the host
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_idx,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_xfer_done,
  input wire logic i_md_valid,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  // Process side per axis
  input wire aifc_pkg::aifc_proc_in_t [NUM_AXES-1:0] i_proc,
  input wire logic [NUM_AXES-1:0] i_is_cam,
  input wire logic [NUM_AXES-1:0] i_adapt_started,
  // Status
  output aifc_pkg::aifc_axis_out_t [NUM_AXES-1:0] o_axis,
  output logic o_programmer_indicator
);

  logic [DATA_W-1:0] func_word_r [NUM_AXES];
  logic [DATA_W-1:0] sampled_r [NUM_AXES];
  logic [DATA_W-1:0] prev_r [NUM_AXES];
  logic [2:0] zm_sync_r [NUM_AXES];
  logic [NUM_AXES-1:0] trig_r;
  logic [NUM_AXES-1:0] sync_r;
  logic [NUM_AXES-1:0] sim_r;
  logic [NUM_AXES-1:0] abort_r;
  logic [NUM_AXES-1:0] skip_r;
  logic [NUM_AXES-1:0] adcont_r;
  logic [NUM_AXES-1:0] cams_off_r;
  logic [31:0] pos_r [NUM_AXES];
  logic [31:0] corr_r [NUM_AXES];
  logic [15:0] cam_r [NUM_AXES];
  logic [7:0] dout_r [NUM_AXES];
  logic [DATA_W-1:0] rdata_r;
  logic rvalid_r;

  function automatic int idx_to_axis(input logic [7:0] idx);
    int a;
    a = -1;
    case (idx)
      aifc_pkg::AXIS1_FUNC_IDX: a = 0;
      aifc_pkg::AXIS2_FUNC_IDX: a = 1;
      aifc_pkg::AXIS3_FUNC_IDX: a = 2;
      default: a = -1;
    endcase
    if (a >= NUM_AXES)
    begin
      a = -1;
    end
    return a;
  endfunction

  function automatic logic status_idle(input aifc_pkg::aifc_axis_st_t s);
    return (s == aifc_pkg::AIFC_ST_COMPLETED) ||
           (s == aifc_pkg::AIFC_ST_INTERRUPTED);
  endfunction

  // Host word writes; the programmer device has no port here at all. Reset
  // leaves programmer mode set so the host must release each axis.
  always_ff @(posedge i_clk)
  begin
    for (int a = 0; a < NUM_AXES; a++)
    begin
      if (i_srst)
      begin
        func_word_r[a] <= DATA_W'(aifc_pkg::FUNC_RESET);
      end
      else if (i_wr && idx_to_axis(i_idx) == a)
      begin
        func_word_r[a] <= i_wdata;
      end
    end
  end

  // Read port stays live in every mode.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= i_rd;
      rdata_r <= '0;
      for (int a = 0; a < NUM_AXES; a++)
      begin
        if (i_rd && idx_to_axis(i_idx) == a)
        begin
          rdata_r <= func_word_r[a];
        end
      end
    end
  end

  // The word is taken over only when the host completes a transfer, so a
  // half-written word never reaches the axis logic.
  always_ff @(posedge i_clk)
  begin
    for (int a = 0; a < NUM_AXES; a++)
    begin
      if (i_srst)
      begin
        sampled_r[a] <= DATA_W'(aifc_pkg::FUNC_RESET);
        prev_r[a] <= DATA_W'(aifc_pkg::FUNC_RESET);
      end
      else
      begin
        prev_r[a] <= sampled_r[a];
        if (i_xfer_done)
        begin
          sampled_r[a] <= func_word_r[a];
        end
        // Without machine data drive disable and follow-up stay off.
        if (!i_md_valid)
        begin
          sampled_r[a][aifc_pkg::BIT_DDIS] <= 1'b0;
          sampled_r[a][aifc_pkg::BIT_FOLL] <= 1'b0;
        end
      end
    end
  end

  // Zero mark is a pin: three flops, with edge detect on the second and third.
  always_ff @(posedge i_clk)
  begin
    for (int a = 0; a < NUM_AXES; a++)
    begin
      if (i_srst)
      begin
        zm_sync_r[a] <= '0;
      end
      else
      begin
        zm_sync_r[a] <= {zm_sync_r[a][1:0], i_proc[a].zero_mark};
      end
    end
  end

  // Trigger reference point state, updated while the axis status is completed or interrupted and held while it runs.
  always_ff @(posedge i_clk)
  begin
    for (int a = 0; a < NUM_AXES; a++)
    begin
      if (i_srst || !i_md_valid)
      begin
        trig_r[a] <= 1'b0;
      end
      else if (status_idle(i_proc[a].status))
      begin
        trig_r[a] <= sampled_r[a][aifc_pkg::BIT_TRIG] &&
                     i_proc[a].incremental &&
                     i_proc[a].has_zero_mark;
      end
    end
  end

  // Simulation run flag, entered on ON, left on OFF or external error.
  always_ff @(posedge i_clk)
  begin
    for (int a = 0; a < NUM_AXES; a++)
    begin
      if (i_srst || !i_md_valid)
      begin
        sim_r[a] <= 1'b0;
      end
      else if (sim_r[a])
      begin
        if (i_proc[a].sim_off_cmd || i_proc[a].ext_error)
        begin
          sim_r[a] <= 1'b0;
        end
      end
      else if (i_proc[a].sim_on_cmd)
      begin
        sim_r[a] <= 1'b1;
      end
    end
  end

  // After a simulation every track stays dark until the next simulation starts or
  // the host completes its next transfer, which is where it re-enables the tracks that it wants.
  always_ff @(posedge i_clk)
  begin
    for (int a = 0; a < NUM_AXES; a++)
    begin
      if (!i_srst && sim_r[a] &&
          (i_proc[a].sim_off_cmd || i_proc[a].ext_error))
      begin
        cams_off_r[a] <= 1'b1;
      end
      else if (i_srst || i_xfer_done || i_proc[a].sim_on_cmd)
      begin
        cams_off_r[a] <= 1'b0;
      end
    end
  end

  // Position, synchronisation and cam outputs. Outside simulation the actual
  // value is the encoder count plus a correction, so that a coordinate set by
  // synchronisation or by the end of a simulation stays in force.
  always_ff @(posedge i_clk)
  begin
    for (int a = 0; a < NUM_AXES; a++)
    begin
      if (i_srst)
      begin
        pos_r[a] <= '0;
        corr_r[a] <= '0;
        sync_r[a] <= 1'b0;
        cam_r[a] <= '0;
      end
      else if (sim_r[a] &&
               (i_proc[a].sim_off_cmd || i_proc[a].ext_error))
      begin
        cam_r[a] <= '0;
        if (i_proc[a].incremental)
        begin
          pos_r[a] <= i_proc[a].ref_coord;
          corr_r[a] <= i_proc[a].ref_coord - i_proc[a].enc_position;
          sync_r[a] <= 1'b0;
        end
        else
        begin
          pos_r[a] <= i_proc[a].enc_position + i_proc[a].ref_coord;
          corr_r[a] <= i_proc[a].ref_coord;
          sync_r[a] <= 1'b1;
        end
      end
      else if (sim_r[a])
      begin
        // Creep speed is deliberately never read here.
        if (i_proc[a].sim_dir_rev)
        begin
          pos_r[a] <= pos_r[a] - i_proc[a].rapid_speed;
        end
        else
        begin
          pos_r[a] <= pos_r[a] + i_proc[a].rapid_speed;
        end
        cam_r[a] <= i_proc[a].cam_states & i_proc[a].track_enable;
      end
      else if (trig_r[a] && !i_proc[a].af_pending &&
               i_proc[a].past_reduction &&
               zm_sync_r[a][1] && !zm_sync_r[a][2])
      begin
        // Only the actual value moves; limits and stored cam and target
        // coordinates live outside this block and are not touched.
        pos_r[a] <= i_proc[a].ref_coord + i_proc[a].offset;
        corr_r[a] <= i_proc[a].ref_coord + i_proc[a].offset -
                     i_proc[a].enc_position;
        sync_r[a] <= 1'b1;
      end
      else
      begin
        pos_r[a] <= i_proc[a].enc_position + corr_r[a];
        cam_r[a] <= cams_off_r[a] ? '0 :
                    (i_proc[a].cam_states & i_proc[a].track_enable);
      end
    end
  end

  // Mode abort, adaption handling and digital outputs.
  always_ff @(posedge i_clk)
  begin
    for (int a = 0; a < NUM_AXES; a++)
    begin
      if (i_srst)
      begin
        abort_r[a] <= 1'b0;
        skip_r[a] <= 1'b0;
        adcont_r[a] <= 1'b0;
        dout_r[a] <= '0;
      end
      else
      begin
        // Pending functions are kept elsewhere; programmer mode never
        // clears them, it aborts the running mode and switches off the digital outputs of a non-cam axis.
        abort_r[a] <= !i_is_cam[a] &&
                      sampled_r[a][aifc_pkg::BIT_PROG] &&
                      !prev_r[a][aifc_pkg::BIT_PROG];
        // A rapid move is only cut once it already decelerates.
        skip_r[a] <= sampled_r[a][aifc_pkg::BIT_DDIS] &&
                     !prev_r[a][aifc_pkg::BIT_DDIS] &&
                     (i_proc[a].status == aifc_pkg::AIFC_ST_RUNNING) &&
                     (!i_proc[a].rapid ||
                      i_proc[a].below_changeover);
        adcont_r[a] <= sampled_r[a][aifc_pkg::BIT_FOLL] &&
                       i_adapt_started[a];
        if (sampled_r[a][aifc_pkg::BIT_DDIS] ||
            (!i_is_cam[a] && sampled_r[a][aifc_pkg::BIT_PROG]))
        begin
          dout_r[a] <= '0;
        end
        else
        begin
          dout_r[a] <= 8'hff;
        end
      end
    end
  end

  always_comb
  begin
    o_programmer_indicator = 1'b0;
    for (int a = 0; a < NUM_AXES; a++)
    begin
      o_programmer_indicator = o_programmer_indicator |
                               sampled_r[a][aifc_pkg::BIT_PROG];
      o_axis[a].prog_mode = sampled_r[a][aifc_pkg::BIT_PROG];
      o_axis[a].trig_active = trig_r[a];
      o_axis[a].drive_disable = sampled_r[a][aifc_pkg::BIT_DDIS];
      o_axis[a].follow_up = sampled_r[a][aifc_pkg::BIT_FOLL];
      o_axis[a].zero_speed_mon = !sampled_r[a][aifc_pkg::BIT_FOLL];
      o_axis[a].synchronized = sync_r[a];
      o_axis[a].sim_running = sim_r[a];
      o_axis[a].abort_mode = abort_r[a];
      o_axis[a].adaption_skip = skip_r[a];
      o_axis[a].adaption_cont = adcont_r[a];
      o_axis[a].position = pos_r[a];
      o_axis[a].cam_out = cam_r[a];
      o_axis[a].dig_out = dout_r[a];
    end
    o_rdata = rdata_r;
    o_rvalid = rvalid_r;
  end

endmodule

// ===== testbench/aifc_axis_ctrl_asserts.sv
`timescale 1ns/1ns
module aifc_axis_ctrl_asserts #(
  parameter int NUM_AXES = 3
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Host side
  input wire logic i_rd,
  input wire logic i_md_valid,
  input wire logic o_rvalid,
  // Process side and status
  input wire aifc_pkg::aifc_proc_in_t [NUM_AXES-1:0] i_proc,
  input wire aifc_pkg::aifc_axis_out_t [NUM_AXES-1:0] o_axis,
  input wire logic o_programmer_indicator
);
  // Only axis 0 is watched in depth; the others share the same logic.
  aifc_pkg::aifc_axis_out_t a;
  aifc_pkg::aifc_proc_in_t p;
  logic any_prog;
  assign a = o_axis[0];
  assign p = i_proc[0];
  always_comb
  begin
    any_prog = 1'h0;
    for (int k = 0; k < NUM_AXES; k++)
    begin
      any_prog = any_prog | o_axis[k].prog_mode;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_run;
    a.sim_running && !p.sim_off_cmd && !p.ext_error && !p.sim_dir_rev;
  endsequence
  sequence s_stop;
    a.sim_running && (p.sim_off_cmd || p.ext_error);
  endsequence
  property p_rd; i_rd |=> o_rvalid; endproperty
  a_rd: assert property (p_rd)
    else $error("read not answered");
  property p_rst; $past(i_srst) |-> a.prog_mode; endproperty
  a_rst: assert property (p_rst)
    else $error("no programmer mode after restart");
  property p_ind; o_programmer_indicator == any_prog; endproperty
  a_ind: assert property (p_ind)
    else $error("indicator wrong");
  property p_md;
    !i_md_valid [*2] |-> !a.drive_disable && !a.follow_up && !a.trig_active;
  endproperty
  a_md: assert property (p_md)
    else $error("function active without machine data");
  property p_ddis;
    a.drive_disable && $past(a.drive_disable) |-> a.dig_out == 8'h00;
  endproperty
  a_ddis: assert property (p_ddis)
    else $error("outputs on under drive disable");
  property p_foll; a.follow_up |-> !a.zero_speed_mon; endproperty
  a_foll: assert property (p_foll)
    else $error("zero speed monitor on in follow-up");
  property p_move;
    s_run ##1 a.sim_running |->
      a.position == $past(a.position) + $past(p.rapid_speed);
  endproperty
  a_move: assert property (p_move)
    else $error("simulated position step wrong");
  property p_cam;
    a.sim_running && $past(a.sim_running) |->
      (a.cam_out & ~$past(p.track_enable)) == 16'h0000;
  endproperty
  a_cam: assert property (p_cam)
    else $error("cam on disabled track");
  property p_end; s_stop |=> a.cam_out == 16'h0000 && !a.sim_running;
  endproperty
  a_end: assert property (p_end)
    else $error("cams left on after simulation");
  property p_incr; s_stop ##0 p.incremental |=>
    a.position == $past(p.ref_coord) && !a.synchronized; endproperty
  a_incr: assert property (p_incr)
    else $error("incremental end of simulation wrong");
  property p_ssi; s_stop ##0 !p.incremental |=> a.synchronized &&
    a.position == $past(p.enc_position) + $past(p.ref_coord); endproperty
  a_ssi: assert property (p_ssi)
    else $error("absolute end of simulation wrong");
endmodule
bind aifc_axis_ctrl aifc_axis_ctrl_asserts #(.NUM_AXES(NUM_AXES)) u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_rd(i_rd), .i_md_valid(i_md_valid),
  .o_rvalid(o_rvalid), .i_proc(i_proc), .o_axis(o_axis),
  .o_programmer_indicator(o_programmer_indicator));

// ===== testbench/aifc_host_model.sv
`timescale 1ns/1ns
module aifc_host_model (
  // Clock
  input wire logic i_clk,
  // Word access towards the device
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_idx,
  output logic [15:0] o_wdata,
  output logic o_xfer_done,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid
);
  initial
  begin
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_idx = 8'h00;
    o_wdata = 16'h0000;
    o_xfer_done = 1'h0;
  end
  // Released lines are inverted so a stale value can never look valid.
  task automatic put(input logic [7:0] idx, input logic [15:0] d);
    @(negedge i_clk);
    o_wr = 1'h1;
    o_idx = idx;
    o_wdata = d;
    @(negedge i_clk);
    o_wr = 1'h0;
    o_idx = ~idx;
    o_wdata = ~d;
    o_xfer_done = 1'h1;
    @(negedge i_clk);
    o_xfer_done = 1'h0;
  endtask
  task automatic get(input logic [7:0] idx, output logic [15:0] d,
                     output logic v);
    @(negedge i_clk);
    o_rd = 1'h1;
    o_idx = idx;
    @(negedge i_clk);
    o_rd = 1'h0;
    o_idx = ~idx;
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule

// ===== testbench/aifc_axis_ctrl_tb.sv
`timescale 1ns/1ns
module aifc_axis_ctrl_tb;
  logic i_clk = 1'h0;
  logic i_srst = 1'h1;
  logic i_wr, i_rd, i_xfer_done, o_rvalid, o_programmer_indicator, rd_v;
  logic [7:0] i_idx;
  logic [15:0] i_wdata, o_rdata, rd_d;
  logic i_md_valid = 1'h1;
  logic [2:0] i_is_cam = 3'h0;
  logic [2:0] i_adapt_started = 3'h0;
  aifc_pkg::aifc_proc_in_t [2:0] i_proc = '0;
  aifc_pkg::aifc_axis_out_t [2:0] o_axis;
  int miscompares = 0;
  int n_checks = 0;
  always #5 i_clk = ~i_clk;
  aifc_axis_ctrl aifc_axis_ctrl_i (
    .i_clk(i_clk), .i_srst(i_srst), .i_wr(i_wr), .i_rd(i_rd),
    .i_idx(i_idx), .i_wdata(i_wdata), .i_xfer_done(i_xfer_done),
    .i_md_valid(i_md_valid), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_proc(i_proc), .i_is_cam(i_is_cam), .i_adapt_started(i_adapt_started),
    .o_axis(o_axis), .o_programmer_indicator(o_programmer_indicator));
  aifc_host_model host_i (
    .i_clk(i_clk), .o_wr(i_wr), .o_rd(i_rd), .o_idx(i_idx),
    .o_wdata(i_wdata), .o_xfer_done(i_xfer_done), .i_rdata(o_rdata),
    .i_rvalid(o_rvalid));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && n_checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic t_reset;
    chk(o_axis[0].prog_mode & o_axis[2].prog_mode, 1'h1);
    chk(o_programmer_indicator, 1'h1);
    chk(o_axis[1].drive_disable | o_axis[1].follow_up, 1'h0);
    chk(o_axis[1].trig_active, 1'h0);
    host_i.get(8'hbc, rd_d, rd_v);
    chk(rd_d, 16'h0001);
  endtask
  task automatic t_prog;
    host_i.put(8'hbc, 16'h0000);
    host_i.put(8'hc2, 16'h0000);
    host_i.put(8'hc8, 16'h0000);
    wt(2);
    chk(o_programmer_indicator, 1'h0);
    chk(o_axis[1].dig_out, 8'hff);
    host_i.put(8'hc2, 16'h0001);
    wt(1);
    chk({o_axis[1].abort_mode, o_axis[1].dig_out}, 9'h100);
    wt(1);
    chk(o_axis[1].abort_mode, 1'h0);
    chk(o_axis[1].prog_mode, 1'h1);
    chk(o_axis[1].dig_out, 8'h00);
    chk(o_programmer_indicator, 1'h1);
    host_i.get(8'hc2, rd_d, rd_v);
    chk({rd_v, rd_d}, 17'h10001);
    host_i.get(8'h00, rd_d, rd_v);
    chk(rd_d, 16'h0000);
    host_i.put(8'hc2, 16'h0000);
  endtask
  task automatic t_ddis;
    i_proc[0].status = aifc_pkg::AIFC_ST_RUNNING;
    i_proc[0].rapid = 1'h1;
    host_i.put(8'hbc, 16'h0004);
    wt(1);
    chk(o_axis[0].adaption_skip, 1'h0);
    host_i.put(8'hbc, 16'h0000);
    i_proc[0].below_changeover = 1'h1;
    host_i.put(8'hbc, 16'h0004);
    wt(1);
    chk(o_axis[0].adaption_skip, 1'h1);
    wt(1);
    chk(o_axis[0].adaption_skip, 1'h0);
    chk({o_axis[0].drive_disable, o_axis[0].dig_out}, 9'h100);
    i_md_valid = 1'h0;
    wt(2);
    chk(o_axis[0].drive_disable, 1'h0);
    i_md_valid = 1'h1;
    host_i.put(8'hbc, 16'h0000);
    wt(2);
    chk(o_axis[0].dig_out, 8'hff);
  endtask
  task automatic t_foll;
    i_adapt_started = 3'h1;
    host_i.put(8'hbc, 16'h0008);
    wt(1);
    chk({o_axis[0].follow_up, o_axis[0].zero_speed_mon}, 2'h2);
    chk(o_axis[0].adaption_cont, 1'h1);
    host_i.put(8'hbc, 16'h0000);
    wt(1);
    chk(o_axis[0].zero_speed_mon, 1'h1);
    chk(o_axis[0].adaption_cont, 1'h0);
    i_adapt_started = 3'h0;
  endtask
  task automatic zmark;
    i_proc[0].zero_mark = 1'h1;
    wt(6);
    i_proc[0].zero_mark = 1'h0;
    wt(2);
  endtask
  task automatic t_trig;
    i_proc[0].incremental = 1'h1;
    i_proc[0].has_zero_mark = 1'h1;
    i_proc[0].ref_coord = 32'h100;
    i_proc[0].offset = 32'h20;
    host_i.put(8'hbc, 16'h0002);
    wt(1);
    chk(o_axis[0].trig_active, 1'h0);
    i_proc[0].status = aifc_pkg::AIFC_ST_COMPLETED;
    host_i.put(8'hbc, 16'h0002);
    wt(1);
    chk(o_axis[0].trig_active, 1'h1);
    i_proc[0].past_reduction = 1'h1;
    i_proc[0].af_pending = 1'h1;
    zmark();
    chk(o_axis[0].synchronized, 1'h0);
    i_proc[0].af_pending = 1'h0;
    zmark();
    chk(o_axis[0].synchronized, 1'h1);
    chk(o_axis[0].position, 32'h120);
  endtask
  task automatic sim_cycle(input logic err);
    logic [31:0] p0;
    i_proc[0].sim_dir_rev = err;
    i_proc[0].sim_on_cmd = 1'h1;
    wt(1);
    i_proc[0].sim_on_cmd = 1'h0;
    p0 = o_axis[0].position;
    wt(4);
    chk(o_axis[0].position, err ? p0 - 32'h14 : p0 + 32'h14);
    chk({o_axis[0].sim_running, o_axis[0].cam_out}, 17'h100f0);
    i_proc[0].sim_off_cmd = ~err;
    i_proc[0].ext_error = err;
    wt(1);
    i_proc[0].sim_off_cmd = 1'h0;
    i_proc[0].ext_error = 1'h0;
    wt(1);
    chk({o_axis[0].sim_running, o_axis[0].cam_out}, 17'h00000);
  endtask
  task automatic t_sim;
    i_is_cam = 3'h1;
    host_i.put(8'hbc, 16'h0001);
    wt(1);
    chk({o_axis[0].abort_mode, o_axis[0].dig_out}, 9'h0ff);
    host_i.put(8'hbc, 16'h0000);
    i_proc[0].track_enable = 16'h00f0;
    i_proc[0].cam_states = 16'hffff;
    i_proc[0].rapid_speed = 32'h5;
    i_proc[0].creep_speed = 32'h7;
    i_proc[0].enc_position = 32'h1000;
    sim_cycle(1'h0);
    chk(o_axis[0].position, 32'h100);
    chk(o_axis[0].synchronized, 1'h0);
    i_proc[0].incremental = 1'h0;
    sim_cycle(1'h1);
    chk(o_axis[0].position, 32'h1100);
    chk(o_axis[0].synchronized, 1'h1);
  endtask
  initial
  begin
    #200000;
    miscompares++;
    final_report();
  end
  initial
  begin
    wt(5);
    i_srst = 1'h0;
    wt(1);
    t_reset();
    t_prog();
    t_ddis();
    t_foll();
    t_trig();
    t_sim();
    final_report();
  end
endmodule
